/* hdl/fc_credit.sv */
// flow-control credit logic: transmit gating, receive allocation, update scheduling
// assumes the link layer signals DLLP slot grants and TLP-in-flight state on this clock
`timescale 1ns/1ns

module fc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module fc_credit
  import fc_credit_pkg::*;
#(
  parameter int                 TIMER_CYC = UPDATE_TIMER_CYC,
  parameter logic [HDR_W-1:0]   RX_HDR_SPACE = 8'h20,
  parameter logic [DAT_W-1:0]   RX_DAT_SPACE = 12'h100,
  parameter logic [DAT_W-1:0]   MAX_PAYLOAD_CRED = 12'h010,
  parameter int                 CPL_BYTES = 4096
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   init_load,
  input  wire fc_credit_pkg::fc_update_s init_limit,
  input  wire logic                   upd_rx_valid,
  input  wire fc_credit_pkg::fc_update_s upd_rx,
  input  wire logic                   tx_valid,
  output logic                        tx_ready,
  input  wire fc_credit_pkg::tlp_cred_s tx_req,
  output logic                        tx_out_valid,
  input  wire logic                   tx_out_ready,
  output fc_credit_pkg::tlp_cred_s    tx_out,
  input  wire logic                   rx_drained,
  input  wire fc_credit_pkg::tlp_cred_s rx_drained_pkt,
  input  wire logic                   rx_arrived,
  input  wire logic [fc_credit_pkg::DAT_W-1:0] rx_arrived_dat,
  input  wire logic                   tlp_in_progress,
  input  wire logic                   dllp_slot,
  output logic                        upd_valid,
  output logic                        upd_high,
  output fc_credit_pkg::fc_update_s   upd_out,
  input  wire logic                   tag_limit_small,
  output logic [6:0]                  tag_limit,
  output logic [fc_credit_pkg::HDR_W-1:0] cpl_hdr_space
);
  import fc_credit_pkg::*;

  function automatic logic [DAT_W-1:0] avail_dat(input logic [DAT_W-1:0] lim, input logic [DAT_W-1:0] used);
    avail_dat = lim - used;
  endfunction
  function automatic logic [HDR_W-1:0] avail_hdr(input logic [HDR_W-1:0] lim, input logic [HDR_W-1:0] used);
    avail_hdr = lim - used;
  endfunction

  logic [HDR_W-1:0] hdr_lim [NUM_FC];
  logic [DAT_W-1:0] dat_lim [NUM_FC];
  logic [HDR_W-1:0] hdr_used [NUM_FC];
  logic [DAT_W-1:0] dat_used [NUM_FC];
  logic [HDR_W-1:0] hdr_alloc [NUM_FC];
  logic [DAT_W-1:0] dat_alloc [NUM_FC];
  logic [DAT_W-1:0] dat_sent [NUM_FC];
  logic [DAT_W-1:0] dat_recv;
  logic [13:0]      timer;
  logic [1:0]       upd_sel;
  logic             infinite_hdr;
  logic             infinite_dat;
  logic             fits;
  logic             fifo_valid;
  logic             fifo_take;
  tlp_cred_s        fifo_out;
  logic [1:0]       ft;
  logic             starve;
  logic             quarter;
  logic             timer_hit;
  logic             upd_send;
  logic [HDR_W-1:0] next_hdr_lim [NUM_FC];
  logic [DAT_W-1:0] next_dat_lim [NUM_FC];
  logic [HDR_W-1:0] next_hdr_used [NUM_FC];
  logic [DAT_W-1:0] next_dat_used [NUM_FC];
  logic [HDR_W-1:0] next_hdr_alloc [NUM_FC];
  logic [DAT_W-1:0] next_dat_alloc [NUM_FC];
  logic [DAT_W-1:0] next_dat_sent [NUM_FC];
  logic [DAT_W-1:0] next_dat_recv;
  logic [13:0]      next_timer;
  fc_update_s       next_upd_out;

  fc_fifo #(.WIDTH($bits(tlp_cred_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_req),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_out)
  );

  assign ft = fifo_out.fc_type;
  always_comb begin
    infinite_hdr = (hdr_lim[ft] == HDR_INFINITE);
    infinite_dat = (dat_lim[ft] == DAT_INFINITE);
    fits = (infinite_hdr || avail_hdr(hdr_lim[ft], hdr_used[ft]) >= 8'h01)
        && (infinite_dat || avail_dat(dat_lim[ft], dat_used[ft]) >= fifo_out.dat);
  end
  // held head resumes once limit rises
  assign fifo_take    = fifo_valid && fits && tx_out_ready;
  assign tx_out_valid = fifo_valid && fits;
  assign tx_out       = fifo_out;

  assign tag_limit     = tag_limit_small ? 7'(TAGS_SMALL) : 7'(TAGS_LARGE);
  assign cpl_hdr_space = HDR_W'(CPL_BYTES / RCB_BYTES);

  // posted class drives the scheduling; non-posted sent when posted hdr_alloc equals posted hdr_lim
  assign upd_sel   = (hdr_alloc[0] != hdr_lim[0]) ? FC_POSTED : FC_NONPOSTED;
  assign starve    = (avail_dat(dat_sent[0], dat_recv) < MAX_PAYLOAD_CRED) && (dat_alloc[0] != dat_sent[0]);
  assign quarter   = avail_dat(dat_alloc[0], dat_sent[0]) >= (RX_DAT_SPACE >> 2);
  assign timer_hit = (timer >= 14'(TIMER_CYC));
  assign upd_high  = starve || quarter || timer_hit;
  assign upd_valid = !srst;
  // only in a free DLLP slot after any TLP
  assign upd_send  = dllp_slot && !tlp_in_progress;

  always_comb begin
    next_timer    = timer;
    next_dat_recv = dat_recv;
    for (int i = 0; i < NUM_FC; i++) begin
      next_hdr_lim[i]   = hdr_lim[i];
      next_dat_lim[i]   = dat_lim[i];
      next_hdr_used[i]  = hdr_used[i];
      next_dat_used[i]  = dat_used[i];
      next_hdr_alloc[i] = hdr_alloc[i];
      next_dat_alloc[i] = dat_alloc[i];
      next_dat_sent[i]  = dat_sent[i];
    end
    next_upd_out.fc_type = upd_sel;
    next_upd_out.hdr     = hdr_alloc[upd_sel];
    next_upd_out.dat     = dat_alloc[upd_sel];
    if (upd_sel == FC_CPL) begin
      next_upd_out.hdr = HDR_INFINITE;
      next_upd_out.dat = DAT_INFINITE;
    end
    // restart on send
    // saturate once expired so the request stays high until an update goes out
    if (upd_send && upd_valid) begin
      next_timer = '0;
    end else if (!timer_hit) begin
      next_timer = timer + 1'b1;
    end
    if (rx_arrived) begin
      next_dat_recv = dat_recv + rx_arrived_dat;
    end
    if (init_load) begin
      next_hdr_lim[init_limit.fc_type] = init_limit.hdr;
      next_dat_lim[init_limit.fc_type] = init_limit.dat;
    end else if (upd_rx_valid) begin
      next_hdr_lim[upd_rx.fc_type] = upd_rx.hdr;
      next_dat_lim[upd_rx.fc_type] = upd_rx.dat;
    end
    if (fifo_take) begin
      next_hdr_used[ft] = hdr_used[ft] + 1'b1;
      next_dat_used[ft] = dat_used[ft] + fifo_out.dat;
    end
    if (rx_drained && rx_drained_pkt.fc_type != FC_CPL) begin
      next_hdr_alloc[rx_drained_pkt.fc_type] = hdr_alloc[rx_drained_pkt.fc_type] + 1'b1;
      next_dat_alloc[rx_drained_pkt.fc_type] = dat_alloc[rx_drained_pkt.fc_type] + rx_drained_pkt.dat;
    end
    if (upd_send) begin
      next_dat_sent[upd_out.fc_type] = upd_out.dat;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      timer    <= '0;
      dat_recv <= '0;
      upd_out  <= '0;
      for (int i = 0; i < NUM_FC; i++) begin
        hdr_lim[i]  <= '0;
        dat_lim[i]  <= '0;
        hdr_used[i] <= '0;
        dat_used[i] <= '0;
        // start at buffer space, completions infinite
        hdr_alloc[i] <= (i == 2) ? HDR_INFINITE : RX_HDR_SPACE;
        dat_alloc[i] <= (i == 2) ? DAT_INFINITE : RX_DAT_SPACE;
        // the initial advertisement already carried the starting allocation
        dat_sent[i]  <= (i == 2) ? DAT_INFINITE : RX_DAT_SPACE;
      end
    end else begin
      timer    <= next_timer;
      dat_recv <= next_dat_recv;
      upd_out  <= next_upd_out;
      for (int i = 0; i < NUM_FC; i++) begin
        hdr_lim[i]   <= next_hdr_lim[i];
        dat_lim[i]   <= next_dat_lim[i];
        hdr_used[i]  <= next_hdr_used[i];
        dat_used[i]  <= next_dat_used[i];
        hdr_alloc[i] <= next_hdr_alloc[i];
        dat_alloc[i] <= next_dat_alloc[i];
        dat_sent[i]  <= next_dat_sent[i];
      end
    end
  end

  a_charge_hdr: assert property (@(posedge clk) disable iff (srst)
    fifo_take |=> hdr_used[$past(ft)] == $past(hdr_used[ft]) + 1'b1)
    else $error("header consumed not charged");
  a_hold_short: assert property (@(posedge clk) disable iff (srst)
    tx_out_valid && hdr_lim[ft] != HDR_INFINITE |-> hdr_lim[ft] != hdr_used[ft])
    else $error("packet offered without credits");
  a_no_preempt: assert property (@(posedge clk) disable iff (srst)
    tlp_in_progress |=> timer != 14'h0000 || $past(timer) == 14'h0000)
    else $error("update sent during TLP");
  a_timer_high: assert property (@(posedge clk) disable iff (srst)
    timer == 14'(TIMER_CYC - 1) && !upd_send |=> upd_high)
    else $error("timer expiry not high priority");
  a_quarter_high: assert property (@(posedge clk) disable iff (srst)
    12'(dat_alloc[0] - dat_sent[0]) >= (RX_DAT_SPACE >> 2) |-> upd_high)
    else $error("quarter growth not high priority");
  a_starve_high: assert property (@(posedge clk) disable iff (srst)
    12'(dat_sent[0] - dat_recv) < MAX_PAYLOAD_CRED && dat_alloc[0] != dat_sent[0] |-> upd_high)
    else $error("starvation not high priority");
  a_limit_load: assert property (@(posedge clk) disable iff (srst)
    upd_rx_valid && !init_load |=> dat_lim[$past(upd_rx.fc_type)] == $past(upd_rx.dat))
    else $error("limit not updated");
  a_tag_sel: assert property (@(posedge clk) disable iff (srst)
    tag_limit == (tag_limit_small ? 7'h20 : 7'h40))
    else $error("tag limit wrong");
  a_alloc_step: assert property (@(posedge clk) disable iff (srst)
    rx_drained && rx_drained_pkt.fc_type == FC_POSTED |=> hdr_alloc[0] == $past(hdr_alloc[0]) + 1'b1)
    else $error("allocation not advanced");
  c_send: cover property (@(posedge clk) disable iff (srst) fifo_take);
  c_stall: cover property (@(posedge clk) disable iff (srst) fifo_valid && !fits);
  c_high: cover property (@(posedge clk) disable iff (srst) upd_high && upd_send);
endmodule

/* hdl/fc_credit_pkg.sv */
// constants and carrier types for the flow-control credit block
// assumes one core clock; header and data counts are in protocol credit units
package fc_credit_pkg;
  localparam int HDR_W = 8;
  localparam int DAT_W = 12;
  localparam int NUM_FC = 3;
  localparam logic [1:0] FC_POSTED = 2'h0;
  localparam logic [1:0] FC_NONPOSTED = 2'h1;
  localparam logic [1:0] FC_CPL = 2'h2;
  localparam logic [HDR_W-1:0] HDR_INFINITE = 8'h00;
  localparam logic [DAT_W-1:0] DAT_INFINITE = 12'h000;
  localparam int CLK_MHZ = 100;
  localparam int UPDATE_TIMER_US = 30;
  localparam int UPDATE_TIMER_CYC = UPDATE_TIMER_US * CLK_MHZ;
  localparam int RCB_BYTES = 64;
  localparam int TAGS_SMALL = 32;
  localparam int TAGS_LARGE = 64;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic [1:0]       fc_type;
    logic [DAT_W-1:0] dat;
  } tlp_cred_s;

  typedef struct packed {
    logic [1:0]       fc_type;
    logic [HDR_W-1:0] hdr;
    logic [DAT_W-1:0] dat;
  } fc_update_s;
endpackage

/* tb/fc_remote_port.sv */
// remote port model: takes offered packets and returns credit updates
// assumes fc_credit samples its inputs on the rising edge of clk
`timescale 1ns/1ns
module fc_remote_port
  import fc_credit_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 tx_out_valid,
  output logic                      tx_out_ready,
  output logic                      upd_rx_valid,
  output fc_credit_pkg::fc_update_s upd_rx,
  output int                        taken
);
  initial begin
    tx_out_ready = 1'b0;
    upd_rx_valid = 1'b0;
    upd_rx = '0;
    taken = 0;
  end
  always @(posedge clk) begin
    if (tx_out_valid && tx_out_ready) begin
      taken <= taken + 1;
    end
  end
  task automatic send_update(input logic [1:0] t, input logic [7:0] h, input logic [11:0] d);
    @(posedge clk);
    upd_rx_valid <= 1'b1;
    upd_rx <= '{t, h, d};
    @(posedge clk);
    upd_rx_valid <= 1'b0;
    // released lines never show the stale value
    upd_rx <= ~upd_rx;
  endtask
  task automatic set_stall(input logic s);
    @(posedge clk);
    tx_out_ready <= ~s;
  endtask
endmodule

/* tb/pcie_flow_control_credits_tb_top.sv */
// self-checking bench for the flow-control credit block
// assumes the remote port model drives the far side
`timescale 1ns/1ns
module pcie_flow_control_credits_tb_top
  import fc_credit_pkg::*;
;
  localparam int CPL_B = 2048;
  logic clk = 1'b0, srst = 1'b1, init_load = 1'b0, tx_valid = 1'b0, rx_drained = 1'b0;
  logic rx_arrived = 1'b0, tlp_in_progress = 1'b0, dllp_slot = 1'b0, tag_limit_small = 1'b0;
  logic tx_ready, tx_out_valid, tx_out_ready, upd_rx_valid, upd_valid, upd_high;
  logic [11:0] rx_arrived_dat = 12'h000;
  logic [6:0] tag_limit;
  logic [7:0] cpl_hdr_space;
  fc_update_s init_limit = '0, upd_rx, upd_out;
  tlp_cred_s tx_req = '0, rx_drained_pkt = '0, tx_out;
  int taken, n, fail_count = 0, check_count = 0;

  always #5 clk = ~clk;

  fc_credit #(.TIMER_CYC(400), .CPL_BYTES(CPL_B)) i_dut (.clk(clk), .srst(srst), .init_load(init_load),
    .init_limit(init_limit), .upd_rx_valid(upd_rx_valid), .upd_rx(upd_rx), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_req(tx_req), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
    .tx_out(tx_out), .rx_drained(rx_drained), .rx_drained_pkt(rx_drained_pkt), .rx_arrived(rx_arrived),
    .rx_arrived_dat(rx_arrived_dat), .tlp_in_progress(tlp_in_progress), .dllp_slot(dllp_slot),
    .upd_valid(upd_valid), .upd_high(upd_high), .upd_out(upd_out), .tag_limit_small(tag_limit_small),
    .tag_limit(tag_limit), .cpl_hdr_space(cpl_hdr_space));
  fc_remote_port i_remote (.clk(clk), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
    .upd_rx_valid(upd_rx_valid), .upd_rx(upd_rx), .taken(taken));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic push(input logic [1:0] t, input logic [11:0] d);
    int k;
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_req <= '{t, d};
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (tx_ready !== 1'b1 && k < 50);
    chk(tx_ready, 1'b1);
    @(posedge clk);
    tx_valid <= 1'b0;
  endtask
  task automatic wait_high(input logic exp);
    int k;
    k = 0;
    @(negedge clk);
    while (upd_high !== exp && k < 6) begin
      @(negedge clk);
      k++;
    end
    chk(upd_high, exp);
  endtask
  task automatic drain(input logic [11:0] d);
    @(posedge clk);
    rx_drained <= 1'b1;
    rx_drained_pkt <= '{FC_POSTED, d};
    @(posedge clk);
    rx_drained <= 1'b0;
  endtask
  task automatic send_dllp(input logic busy);
    @(posedge clk);
    tlp_in_progress <= busy;
    dllp_slot <= 1'b1;
    @(posedge clk);
    dllp_slot <= 1'b0;
    tlp_in_progress <= 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic t_static;
    @(posedge clk);
    tag_limit_small <= 1'b1;
    @(negedge clk);
    chk(upd_valid, 1'b1);
    chk(tag_limit, TAGS_SMALL);
    chk(cpl_hdr_space, CPL_B / RCB_BYTES);
    chk(tag_limit * RCB_BYTES <= CPL_B, 1'b1);
    @(posedge clk);
    tag_limit_small <= 1'b0;
    @(negedge clk);
    chk(tag_limit, TAGS_LARGE);
  endtask
  task automatic t_tx_gate;
    @(posedge clk);
    init_load <= 1'b1;
    init_limit <= '{FC_POSTED, 8'h02, 12'h008};
    @(posedge clk);
    init_load <= 1'b0;
    repeat (FIFO_DEPTH) push(FC_POSTED, 12'h004);
    @(negedge clk);
    chk(tx_ready, 1'b0);
    chk(tx_out_valid, 1'b1);
    chk(tx_out.dat, 12'h004);
    chk(tx_out.fc_type, FC_POSTED);
    i_remote.set_stall(1'b0);
    repeat (10) @(negedge clk);
    chk(taken, 2);
    chk(tx_out_valid, 1'b0);
    i_remote.send_update(FC_POSTED, 8'h08, 12'h018);
    repeat (10) @(negedge clk);
    chk(taken, 6);
    i_remote.send_update(FC_POSTED, 8'h08, 12'h040);
    repeat (10) @(negedge clk);
    chk(taken, 8);
    push(FC_POSTED, 12'h000);
    repeat (5) @(negedge clk);
    chk(taken, 8);
    i_remote.send_update(FC_POSTED, 8'h0A, 12'h040);
    push(FC_POSTED, 12'h004);
    repeat (5) @(negedge clk);
    chk(taken, 10);
    push(FC_CPL, 12'h800);
    push(FC_CPL, 12'h800);
    repeat (5) @(negedge clk);
    chk(taken, 12);
  endtask
  task automatic t_sched;
    send_dllp(1'b0);
    wait_high(1'b0);
    drain(12'h040);
    wait_high(1'b1);
    // the update word is registered one cycle behind the allocation
    @(negedge clk);
    chk(upd_out.dat, 12'h140);
    chk(upd_out.hdr, 8'h21);
    send_dllp(1'b1);
    wait_high(1'b1);
    send_dllp(1'b0);
    wait_high(1'b0);
    repeat (200) @(negedge clk);
    wait_high(1'b0);
    n = 0;
    while (upd_high !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(upd_high, 1'b1);
    chk(n > 150, 1'b1);
    send_dllp(1'b0);
    @(posedge clk);
    rx_arrived <= 1'b1;
    rx_arrived_dat <= 12'h135;
    @(posedge clk);
    rx_arrived <= 1'b0;
    wait_high(1'b0);
    drain(12'h001);
    wait_high(1'b1);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_static();
    t_tx_gate();
    t_sched();
    print_verdict();
  end
endmodule
